// *** logic/osa_pkg.sv ***
// package for the output signal allocator: constants, layouts, types
package osa_pkg;
	// number of routed status signals and sequence output pairs
	localparam int OSA_NUM_SIGNALS = 9;
	localparam int OSA_NUM_PAIRS = 3;
	localparam int OSA_ROUTE_BITS = 2;
	// routing field values: 0 unrouted, 1..3 select a pair
	localparam logic [1:0] OSA_ROUTE_NONE = 2'h0;
	// status signal positions inside the status vector
	localparam int OSA_SIG_POSITION_DONE = 0;
	localparam int OSA_SIG_SPEED_MATCH = 1;
	localparam int OSA_SIG_ROTATION = 2;
	localparam int OSA_SIG_SERVO_READY = 3;
	localparam int OSA_SIG_TORQUE_LIMIT = 4;
	localparam int OSA_SIG_SPEED_LIMIT = 5;
	localparam int OSA_SIG_BRAKE_RELEASE = 6;
	localparam int OSA_SIG_WARNING = 7;
	localparam int OSA_SIG_NEAR_POSITION = 8;
	// register offsets
	localparam logic [3:0] OSA_ADDR_ROUTE_A = 4'h0;
	localparam logic [3:0] OSA_ADDR_ROUTE_B = 4'h1;
	localparam logic [3:0] OSA_ADDR_ROUTE_C = 4'h2;
	localparam logic [3:0] OSA_ADDR_INVERT = 4'h3;
	localparam logic [3:0] OSA_ADDR_PAIRS = 4'h4;
	localparam logic [3:0] OSA_ADDR_IRQ_STATUS = 4'h5;
	localparam logic [3:0] OSA_ADDR_IRQ_ENABLE = 4'h6;
	localparam logic [3:0] OSA_ADDR_IRQ_CLEAR = 4'h7;
	// values after reset
	localparam logic [7:0] OSA_ROUTE_A_RESET = 8'h00;
	localparam logic [7:0] OSA_ROUTE_B_RESET = 8'h00;
	localparam logic [1:0] OSA_ROUTE_C_RESET = 2'h0;
	localparam logic [2:0] OSA_INVERT_RESET = 3'h0;
	// interrupt bit positions
	localparam int OSA_IRQ_MONITOR_CHANGE = 0;
	localparam int OSA_IRQ_BITS = 4;
	// safety monitor timing: 20 ms longest delay at 100 MHz
	localparam int OSA_CLOCK_MHZ = 100;
	localparam int OSA_MONITOR_DELAY_MS = 20;
	localparam int OSA_MONITOR_DELAY_CYCLES = OSA_MONITOR_DELAY_MS * 1000 * OSA_CLOCK_MHZ;
	// debounce used on base-block channels, well below the longest delay
	localparam int OSA_FILTER_CYCLES = 1000;
	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} osa_bus_req_type;
	// quadrature pulse output set
	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic origin;
	} osa_pulse_type;
endpackage : osa_pkg

// *** logic/osa_filter.sv ***
// one base-block channel: synchroniser and stability filter
`timescale 1ns/1ns
module osa_filter #(
	parameter int FILTER_CYCLES = 1000
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// raw pin and filtered level
	input wire logic pin_in,
	output logic level_out
);
	localparam int CW = $clog2(FILTER_CYCLES + 1);
	logic sync1_reg; // first stage, read only by second
	logic sync2_reg;
	logic [CW-1:0] count_reg;
	logic level_reg;
	wire differs = sync2_reg != level_reg;
	wire expired = count_reg == CW'(FILTER_CYCLES - 1);
	// double flop the pin
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end
	// accept a new level only after it held steady, so glitches never reach the monitor
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			count_reg <= '0;
			level_reg <= 1'b0;
		end else if (!differs) begin
			count_reg <= '0;
		end else if (expired) begin
			count_reg <= '0;
			level_reg <= sync2_reg;
		end else begin
			count_reg <= count_reg + 1'b1;
		end
	end
	assign level_out = level_reg;
endmodule : osa_filter

// *** logic/osa_top.sv ***
// output signal allocator: routing, polarity, safety monitor, pulse output
//
// Overview of operation
// R1: field value 1..3 picks pair, 0 unrouted
// R2: per-pair inversion flips driven pair level
// R3: inversion settings reset to non-inverted
// R4: monitor on when both channels healthy
// R5: monitor off when any channel unhealthy
// R6: monitor follows channel change within 20 ms
// R7: encoder data becomes quadrature plus origin, differential
// R8: several signals on one pair are ORed
// R9: status not valid in mode counts inactive
//
// register map, eight bit registers
// 0 routing: ready, rotation, speed match, position done
// 1 routing: warning, brake, speed limit, torque limit
// 2 routing: near position
// 3 pair inversion, one bit per pair
// 4 read only: channel health and pair levels
// 5 read only: sticky events, monitor then pairs
// 6 event enable, same layout as the events
// 7 write one to clear events
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module osa_top #(
	parameter int FILTER_CYCLES = osa_pkg::OSA_FILTER_CYCLES
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// register port
	input wire osa_pkg::osa_bus_req_type bus_in,
	output logic [7:0] rdata_out,
	output logic irq_out,
	// internal status signals and their validity in the current mode
	input wire logic [osa_pkg::OSA_NUM_SIGNALS-1:0] status_in,
	input wire logic [osa_pkg::OSA_NUM_SIGNALS-1:0] status_valid_in,
	// hardware base-block channels, high while healthy
	input wire logic base_block_ch1_in,
	input wire logic base_block_ch2_in,
	// encoder position, phase counts from serial decoder
	input wire logic [15:0] encoder_position_in,
	input wire logic encoder_strobe_in,
	input wire logic [15:0] origin_position_in,
	// sequence output pairs
	output logic [osa_pkg::OSA_NUM_PAIRS-1:0] pair_out,
	// safety monitor
	output logic safety_monitor_out,
	// differential pulse outputs
	output osa_pkg::osa_pulse_type pulse_pos_out,
	output osa_pkg::osa_pulse_type pulse_neg_out
);
	import osa_pkg::*;

	logic [7:0] route_a_reg; // four fields: position, speed match, rotation, ready
	logic [7:0] route_b_reg; // four fields: torque, speed limit, brake, warning
	logic [1:0] route_c_reg; // near position field
	logic [2:0] invert_reg; // output_inversion_settings
	logic [2:0] pair_reg;
	logic [7:0] rdata_reg;
	logic [OSA_IRQ_BITS-1:0] irq_status_reg;
	logic [OSA_IRQ_BITS-1:0] irq_enable_reg;
	logic irq_reg;
	logic monitor_reg;
	logic [15:0] last_pos_reg;
	logic [1:0] quad_reg; // gray step state
	logic origin_reg;
	logic ch1_ok;
	logic ch2_ok;

	// bus decode
	wire wr_route_a = bus_in.write && bus_in.addr == OSA_ADDR_ROUTE_A;
	wire wr_route_b = bus_in.write && bus_in.addr == OSA_ADDR_ROUTE_B;
	wire wr_route_c = bus_in.write && bus_in.addr == OSA_ADDR_ROUTE_C;
	wire wr_invert = bus_in.write && bus_in.addr == OSA_ADDR_INVERT;
	wire wr_enable = bus_in.write && bus_in.addr == OSA_ADDR_IRQ_ENABLE;
	wire wr_clear = bus_in.write && bus_in.addr == OSA_ADDR_IRQ_CLEAR;

	// per-signal routing fields gathered into one vector
	wire [OSA_NUM_SIGNALS*OSA_ROUTE_BITS-1:0] fields = {route_c_reg, route_b_reg, route_a_reg};

	// masked status: signals not detected in this mode read as inactive
	wire [OSA_NUM_SIGNALS-1:0] active = status_in & status_valid_in; // [R9]

	// OR of every signal routed to each pair
	logic [OSA_NUM_PAIRS-1:0] pair_or;
	always_comb begin
		pair_or = '0;
		for (int s = 0; s < OSA_NUM_SIGNALS; s++) begin
			for (int p = 0; p < OSA_NUM_PAIRS; p++) begin
				// value 0 matches no pair, so the signal stays unrouted
				if (fields[s*OSA_ROUTE_BITS +: OSA_ROUTE_BITS] == 2'(p + 1) && active[s]) begin
					pair_or[p] = 1'b1; // [R1] [R8]
				end
			end
		end
	end
	wire [2:0] pair_next = pair_or ^ invert_reg; // [R2]

	// filtered base-block channels; filter far shorter than the 20 ms bound
	osa_filter #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_filter_ch1 (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.pin_in(base_block_ch1_in),
		.level_out(ch1_ok)
	);
	osa_filter #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_filter_ch2 (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.pin_in(base_block_ch2_in),
		.level_out(ch2_ok)
	);
	// the monitor is on only while both filtered channels report healthy;
	// one channel dropping is enough to turn it off
	wire monitor_next = ch1_ok && ch2_ok; // [R4] [R5]
	wire monitor_change = monitor_next != monitor_reg;

	// read mux; unmapped and write-only addresses read zero
	logic [7:0] rdata_next;
	always_comb begin
		case (bus_in.addr)
			OSA_ADDR_ROUTE_A: rdata_next = route_a_reg;
			OSA_ADDR_ROUTE_B: rdata_next = route_b_reg;
			OSA_ADDR_ROUTE_C: rdata_next = {6'h00, route_c_reg};
			OSA_ADDR_INVERT: rdata_next = {5'h00, invert_reg};
			OSA_ADDR_PAIRS: rdata_next = {3'h0, ch2_ok, ch1_ok, pair_reg};
			OSA_ADDR_IRQ_STATUS: rdata_next = {4'h0, irq_status_reg};
			OSA_ADDR_IRQ_ENABLE: rdata_next = {4'h0, irq_enable_reg};
			default: rdata_next = 8'h00;
		endcase
		// read data is zero outside the cycle after a read
		if (!bus_in.read) begin
			rdata_next = 8'h00;
		end
	end

	// events: bit 0 a monitor change, bits 1 to 3 a level change on pair 0 to 2
	// each pair has its own bit so software can tell which output moved
	wire [OSA_NUM_PAIRS-1:0] pair_change = pair_next ^ pair_reg;
	wire [OSA_IRQ_BITS-1:0] events = {pair_change, monitor_change};
	// set wins over a clear in the same cycle
	wire [OSA_IRQ_BITS-1:0] irq_status_next =
		(irq_status_reg & ~(wr_clear ? bus_in.wdata[OSA_IRQ_BITS-1:0] : '0)) | events;

	// configuration registers
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			route_a_reg <= OSA_ROUTE_A_RESET;
			route_b_reg <= OSA_ROUTE_B_RESET;
			route_c_reg <= OSA_ROUTE_C_RESET;
			invert_reg <= OSA_INVERT_RESET; // [R3]
			irq_enable_reg <= '0;
		end else begin
			// upper bits of the narrow registers are dropped, they read back zero
			if (wr_route_a) begin
				route_a_reg <= bus_in.wdata; // [R1]
			end
			if (wr_route_b) begin
				route_b_reg <= bus_in.wdata; // [R1]
			end
			if (wr_route_c) begin
				route_c_reg <= bus_in.wdata[1:0]; // [R1]
			end
			if (wr_invert) begin
				invert_reg <= bus_in.wdata[2:0]; // [R2]
			end
			if (wr_enable) begin
				irq_enable_reg <= bus_in.wdata[OSA_IRQ_BITS-1:0];
			end
		end
	end

	// outputs, status and read data
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			pair_reg <= 3'h0;
			monitor_reg <= 1'b0;
			rdata_reg <= 8'h00;
			irq_status_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			pair_reg <= pair_next;
			monitor_reg <= monitor_next; // [R6]
			rdata_reg <= rdata_next;
			irq_status_reg <= irq_status_next;
			irq_reg <= |(irq_status_next & irq_enable_reg);
		end
	end

	// pulse path: each position step advances the gray quadrature state
	wire step_up = encoder_strobe_in && (encoder_position_in == last_pos_reg + 16'h0001);
	wire step_dn = encoder_strobe_in && (encoder_position_in == last_pos_reg - 16'h0001);
	// limitation: jumps larger than one count per strobe produce no pulses
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			last_pos_reg <= 16'h0000;
			quad_reg <= 2'h0;
			origin_reg <= 1'b0;
		end else begin
			// every strobe refreshes the reference and the origin flag
			if (encoder_strobe_in) begin
				last_pos_reg <= encoder_position_in;
				origin_reg <= encoder_position_in == origin_position_in; // [R7]
			end
			// forward walks 00 01 11 10, backward walks the same ring the other way
			if (step_up) begin
				quad_reg <= {quad_reg[0], ~quad_reg[1]}; // [R7]
			end else if (step_dn) begin
				quad_reg <= {~quad_reg[0], quad_reg[1]}; // [R7]
			end
		end
	end

	// drive outputs straight from flops; negative leg is complement
	assign pair_out = pair_reg;
	assign safety_monitor_out = monitor_reg;
	assign rdata_out = rdata_reg;
	assign irq_out = irq_reg;
	assign pulse_pos_out = '{phase_a: quad_reg[1], phase_b: quad_reg[0], origin: origin_reg};
	assign pulse_neg_out = '{phase_a: ~quad_reg[1], phase_b: ~quad_reg[0], origin: ~origin_reg};
endmodule : osa_top

// *** verification/osa_top_asserts.sv ***
// checker for routing, polarity, monitor and pulse outputs
`timescale 1ns/1ns
module osa_top_asserts #(
	parameter int FILTER_CYCLES = 4
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// watched inputs
	input wire osa_pkg::osa_bus_req_type bus_in,
	input wire logic [8:0] status_in,
	input wire logic [8:0] status_valid_in,
	input wire logic base_block_ch1_in,
	input wire logic base_block_ch2_in,
	// watched outputs
	input wire logic [2:0] pair_out,
	input wire logic safety_monitor_out,
	input wire osa_pkg::osa_pulse_type pulse_pos_out,
	input wire osa_pkg::osa_pulse_type pulse_neg_out
);
	import osa_pkg::*;
	logic [17:0] rt_reg; // shadow routing fields
	logic [2:0] inv_reg; // shadow inversion
	logic [2:0] orv; // routed OR before inversion
	logic [15:0] ok_cnt; // cycles both channels healthy
	logic [15:0] bad_cnt; // cycles a channel unhealthy
	wire both_ok = base_block_ch1_in & base_block_ch2_in;
	wire [8:0] act = status_in & status_valid_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	// shadow writes; counters give the monitor a bounded latency
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			rt_reg <= '0;
			inv_reg <= '0;
			ok_cnt <= '0;
			bad_cnt <= '0;
		end else begin
			ok_cnt <= both_ok ? ok_cnt + 16'h1 : 16'h0;
			bad_cnt <= both_ok ? 16'h0 : bad_cnt + 16'h1;
			if (bus_in.write && bus_in.addr == OSA_ADDR_ROUTE_A) rt_reg[7:0] <= bus_in.wdata;
			if (bus_in.write && bus_in.addr == OSA_ADDR_ROUTE_B) rt_reg[15:8] <= bus_in.wdata;
			if (bus_in.write && bus_in.addr == OSA_ADDR_ROUTE_C) rt_reg[17:16] <= bus_in.wdata[1:0];
			if (bus_in.write && bus_in.addr == OSA_ADDR_INVERT) inv_reg <= bus_in.wdata[2:0];
		end
	end
	// expected OR per pair
	always_comb begin
		orv = 3'h0;
		for (int i = 0; i < 9; i++)
			if (act[i] && rt_reg[2*i+:2] != OSA_ROUTE_NONE) orv[rt_reg[2*i+:2]-2'h1] = 1'b1;
	end
	chk_pair_map: assert property (pair_out == $past(orv ^ inv_reg))
		else $error("pair map");
	chk_or_merge: assert property ($past(inv_reg) == 3'h0 |-> pair_out == $past(orv))
		else $error("or merge");
	chk_invert_flip: assert property ($past(act) == 9'h0 |-> pair_out == $past(inv_reg))
		else $error("invert");
	chk_invalid_off: assert property (status_valid_in == 9'h0 |=> pair_out == $past(inv_reg))
		else $error("invalid");
	chk_after_reset: assert property ($past(reset_in, 2) |-> pair_out == $past(orv))
		else $error("reset polarity");
	chk_mon_on: assert property (ok_cnt > FILTER_CYCLES + 6 |-> safety_monitor_out)
		else $error("monitor on");
	chk_mon_off: assert property (bad_cnt > FILTER_CYCLES + 6 |-> !safety_monitor_out)
		else $error("monitor off");
	chk_pulse_diff: assert property (pulse_neg_out == ~pulse_pos_out)
		else $error("differential");
	cover property ($fell(safety_monitor_out));
	cover property (pulse_pos_out.origin);
	cover property (pair_out == 3'h6);
endmodule : osa_top_asserts
bind osa_top osa_top_asserts #(.FILTER_CYCLES(FILTER_CYCLES)) chk_u (
	.clock_in(clock_in),
	.reset_in(reset_in),
	.bus_in(bus_in),
	.status_in(status_in),
	.status_valid_in(status_valid_in),
	.base_block_ch1_in(base_block_ch1_in),
	.base_block_ch2_in(base_block_ch2_in),
	.pair_out(pair_out),
	.safety_monitor_out(safety_monitor_out),
	.pulse_pos_out(pulse_pos_out),
	.pulse_neg_out(pulse_neg_out)
);

// *** verification/osa_host.sv ***
// host model: line receiver counting quadrature edges
`timescale 1ns/1ns
module osa_host (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// differential pulse pairs
	input wire osa_pkg::osa_pulse_type pos_in,
	input wire osa_pkg::osa_pulse_type neg_in,
	// decoded edge count and origin
	output logic [7:0] edges_out,
	output logic origin_out
);
	import osa_pkg::*;
	logic [1:0] ab_reg; // last received phases
	// a receiver only sees a level where both wires disagree
	wire [1:0] ab = {pos_in.phase_a & ~neg_in.phase_a, pos_in.phase_b & ~neg_in.phase_b};
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			ab_reg <= 2'h0;
			edges_out <= 8'h0;
			origin_out <= 1'b0;
		end else begin
			ab_reg <= ab;
			origin_out <= pos_in.origin & ~neg_in.origin;
			if (ab != ab_reg) edges_out <= edges_out + 8'h1;
		end
	end
endmodule : osa_host

// *** verification/output_signal_allocator_bench.sv ***
// directed bench for the output signal allocator
`timescale 1ns/1ns
module output_signal_allocator_bench;
	import osa_pkg::*;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	osa_bus_req_type bus_in = '0;
	logic [8:0] status_in = '0;
	logic [8:0] status_valid_in = '0;
	logic base_block_ch1_in = 1'b1;
	logic base_block_ch2_in = 1'b1;
	logic [15:0] encoder_position_in = '0;
	logic encoder_strobe_in = 1'b0;
	logic [7:0] rdata_out, edges;
	logic irq_out, safety_monitor_out, origin;
	logic [2:0] pair_out;
	osa_pulse_type pulse_pos_out, pulse_neg_out;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	always #5 clock_in = ~clock_in;
	osa_top #(.FILTER_CYCLES(4)) dut_u (.clock_in(clock_in), .reset_in(reset_in),
		.bus_in(bus_in), .rdata_out(rdata_out), .irq_out(irq_out), .status_in(status_in),
		.status_valid_in(status_valid_in), .base_block_ch1_in(base_block_ch1_in),
		.base_block_ch2_in(base_block_ch2_in), .encoder_position_in(encoder_position_in),
		.encoder_strobe_in(encoder_strobe_in), .origin_position_in(16'h0002),
		.pair_out(pair_out), .safety_monitor_out(safety_monitor_out),
		.pulse_pos_out(pulse_pos_out), .pulse_neg_out(pulse_neg_out));
	osa_host host_u (.clock_in(clock_in), .reset_in(reset_in), .pos_in(pulse_pos_out),
		.neg_in(pulse_neg_out), .edges_out(edges), .origin_out(origin));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// write, then an idle edge so strobes never merge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus_in <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_in);
		bus_in <= '0;
		@(posedge clock_in);
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		bus_in <= '{a, 8'h0, 1'b0, 1'b1};
		@(posedge clock_in);
		bus_in <= '0;
		@(negedge clock_in);
		chk("rdata", rdata_out, e);
		@(posedge clock_in);
		@(negedge clock_in);
		chk("rdata idle", rdata_out, 8'h00);
		@(posedge clock_in);
	endtask : rc
	task automatic pc(input logic [8:0] s, input logic [8:0] v, input logic [2:0] e);
		status_in <= s;
		status_valid_in <= v;
		@(posedge clock_in);
		@(negedge clock_in);
		chk("pair", pair_out, e);
		@(posedge clock_in);
	endtask : pc
	task automatic sp(input logic [15:0] p);
		encoder_position_in <= p;
		encoder_strobe_in <= 1'b1;
		@(posedge clock_in);
		encoder_strobe_in <= 1'b0;
		repeat (4) @(posedge clock_in);
	endtask : sp
	task automatic bb(input logic c1, input logic c2, input logic e);
		base_block_ch1_in <= c1;
		base_block_ch2_in <= c2;
		repeat (12) @(posedge clock_in);
		@(negedge clock_in);
		chk("monitor", safety_monitor_out, e);
		@(posedge clock_in);
	endtask : bb
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		repeat (10) @(posedge clock_in);
		reset_in <= 1'b0;
		@(posedge clock_in);
		rc(OSA_ADDR_INVERT, 8'h0);
		pc(9'h1ff, 9'h1ff, 3'h0);
		for (int v = 1; v < 4; v++) begin
			wr(OSA_ADDR_ROUTE_A, 8'(v));
			pc(9'h001, 9'h1ff, 3'(1 << (v - 1)));
		end
		wr(OSA_ADDR_ROUTE_A, 8'h11);
		pc(9'h005, 9'h1ff, 3'h1);
		wr(OSA_ADDR_ROUTE_B, 8'h20);
		wr(OSA_ADDR_ROUTE_C, 8'h03);
		pc(9'h140, 9'h1ff, 3'h6);
		pc(9'h145, 9'h000, 3'h0);
		wr(OSA_ADDR_INVERT, 8'h05);
		pc(9'h004, 9'h1ff, 3'h4);
		rc(OSA_ADDR_PAIRS, 8'h1c);
		rc(4'h8, 8'h0);
		$display("test routing done");
		rc(OSA_ADDR_IRQ_STATUS, 8'h0f);
		wr(OSA_ADDR_IRQ_CLEAR, 8'h0f);
		wr(OSA_ADDR_IRQ_ENABLE, 8'h01);
		bb(1'b0, 1'b1, 1'b0);
		chk("irq", irq_out, 1'b1);
		wr(OSA_ADDR_IRQ_CLEAR, 8'h01);
		@(negedge clock_in);
		chk("irq", irq_out, 1'b0);
		@(posedge clock_in);
		wr(OSA_ADDR_IRQ_ENABLE, 8'h00);
		bb(1'b1, 1'b1, 1'b1);
		chk("irq", irq_out, 1'b0);
		rc(OSA_ADDR_IRQ_STATUS, 8'h01);
		bb(1'b1, 1'b0, 1'b0);
		bb(1'b1, 1'b1, 1'b1);
		$display("test monitor done");
		sp(16'h1);
		sp(16'h2);
		chk("origin", origin, 1'b1);
		sp(16'h3);
		sp(16'h3);
		chk("steps", edges, 8'h3);
		sp(16'h2);
		chk("steps", edges, 8'h4);
		chk("origin", origin, 1'b1);
		$display("test pulse done");
		end_sim();
	end
endmodule : output_signal_allocator_bench
